// *** verification/flash_array_model.sv ***
/*
 * flash array stand-in: answers forwarded reads after a random wait.
 * assumes one forwarded read at a time, as one-cycle pulses on flash_valid_i.
 */
`timescale 1ns/10ps
module flash_array_model (
  // clock
  input wire logic clk_i,
  // forwarded operation
  input wire logic flash_valid_i,
  input wire option_security_reset_init_pkg::flash_req_t flash_req_i,
  // read answer
  output logic flash_rvalid_o,
  output logic [7:0] flash_rdata_o
);
  import option_security_reset_init_pkg::*;
  int lat;
  // ---------------------------------------------
  // read responder, data is address low byte ^ 5A
  // ---------------------------------------------
  initial begin
    flash_rvalid_o = 1'b0;
    flash_rdata_o = 8'hA5;
    forever begin
      @(posedge clk_i);
      if (flash_valid_i === 1'b1 && flash_req_i.cmd == CMD_READ) begin
        lat = 1 + ($urandom % 4);
        repeat (lat - 1) @(posedge clk_i);
        #1;
        flash_rvalid_o = 1'b1;
        flash_rdata_o = flash_req_i.addr[7:0] ^ 8'h5A;
        @(posedge clk_i);
        #1;
        flash_rvalid_o = 1'b0;
        flash_rdata_o = ~flash_rdata_o;
      end
    end
  end
endmodule

// *** verification/option_security_reset_init_bench.sv ***
/*
 * bench for the configuration byte loader, model compared at every result.
 * assumes flash_array_model answers forwarded reads with address ^ 5A.
 */
`timescale 1ns/10ps
module option_security_reset_init_bench;
  import option_security_reset_init_pkg::*;
  localparam int T0 = 2;
  logic ref_clk_i, rst_n_i, reset_pin_n_i, brownout_i, clk_slow_i, halt_req_i;
  logic prog_valid_i, prog_mode_i, user_isp_i, cpu_we_i, flash_rvalid_i;
  logic [7:0] flash_cfg_i, cpu_wdata_i, flash_rdata_i, prog_rdata_o, config_fuse_byte_o;
  flash_req_t prog_req_i, flash_req_o;
  cpu_sel_t cpu_sel_i;
  logic prog_ack_o, prog_refused_o, prog_rvalid_o, flash_valid_o, boot_from_flash_o;
  logic halt_active_o, chip_reset_o, ports_tristate_o, watchdog_out_pin_o;
  logic watchdog_out_pin_oe_o, clk_mon_armed_o;
  logic [1:0] g_pullup_o, wd_window_o;
  init_regs_t init_regs_o;
  kept_regs_t kept_regs_o;
  int err_total = 0;
  int check_count = 0;
  int cyc = 0;
  logic [7:0] m_cfg, sio;
  logic m_wr;
  int i, n;
  option_security_reset_init #(.PROG_TIMING_REG_RESET(PROG_TIMING_REG_10MHZ), .T0_DIVIDE(T0)) uut (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reset_pin_n_i(reset_pin_n_i),
    .brownout_i(brownout_i), .clk_slow_i(clk_slow_i), .halt_req_i(halt_req_i),
    .flash_cfg_i(flash_cfg_i), .prog_valid_i(prog_valid_i), .prog_mode_i(prog_mode_i),
    .user_isp_i(user_isp_i), .prog_req_i(prog_req_i), .prog_ack_o(prog_ack_o),
    .prog_refused_o(prog_refused_o), .prog_rvalid_o(prog_rvalid_o),
    .prog_rdata_o(prog_rdata_o), .flash_valid_o(flash_valid_o), .flash_req_o(flash_req_o),
    .flash_rvalid_i(flash_rvalid_i), .flash_rdata_i(flash_rdata_i), .cpu_we_i(cpu_we_i),
    .cpu_sel_i(cpu_sel_i), .cpu_wdata_i(cpu_wdata_i), .config_fuse_byte_o(config_fuse_byte_o),
    .boot_from_flash_o(boot_from_flash_o), .halt_active_o(halt_active_o),
    .chip_reset_o(chip_reset_o), .init_regs_o(init_regs_o), .kept_regs_o(kept_regs_o),
    .ports_tristate_o(ports_tristate_o), .g_pullup_o(g_pullup_o),
    .watchdog_out_pin_o(watchdog_out_pin_o), .watchdog_out_pin_oe_o(watchdog_out_pin_oe_o),
    .wd_window_o(wd_window_o), .clk_mon_armed_o(clk_mon_armed_o));
  flash_array_model fam (.clk_i(ref_clk_i), .flash_valid_i(flash_valid_o),
    .flash_req_i(flash_req_o), .flash_rvalid_o(flash_rvalid_i), .flash_rdata_o(flash_rdata_i));
  // ---------------------------------------------
  // clock, timeout, compare tasks
  // ---------------------------------------------
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_regs(input init_regs_t e, input init_regs_t g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("Error init_regs expected %h seen %h", e, g);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk_i);
    #1;
  endtask
  // ---------------------------------------------
  // reset helpers
  // ---------------------------------------------
  function automatic init_regs_t init_exp();
    init_regs_t r;
    r = '0;
    r.stack_ptr = 8'h6F;
    r.idle_timer_control[6] = 1'b1;
    r.uart_control_reg[TX_BUFFER_EMPTY_FLAG_BIT] = 1'b1;
    r.prog_timing_reg = PROG_TIMING_REG_10MHZ;
    return r;
  endfunction
  task automatic wait_rel(output int k);
    k = 0;
    while (chip_reset_o !== 1'b0 && k < 3000) begin
      tick(1);
      k++;
    end
  endtask
  task automatic post_chk();
    chk_regs(init_exp(), init_regs_o);
    chk_byte("cfg_byte", m_cfg, config_fuse_byte_o);
    chk_bit("boot_flash", m_cfg[0], boot_from_flash_o);
    chk_bit("wd_oe", ~m_cfg[2], watchdog_out_pin_oe_o);
    chk_bit("ports_tristate", 1'b0, ports_tristate_o);
    chk_byte("g_pullup", 8'h00, {6'h00, g_pullup_o});
    if (!m_cfg[2]) begin
      chk_byte("wd_window", 8'h03, {6'h00, wd_window_o});
      chk_bit("clk_mon", 1'b1, clk_mon_armed_o);
      chk_bit("wd_pin", 1'b1, watchdog_out_pin_o);
    end
  endtask
  task automatic por(input logic [7:0] cfg);
    rst_n_i = 1'b0;
    flash_cfg_i = cfg;
    tick(8);
    chk_bit("reset_active", 1'b1, chip_reset_o);
    chk_bit("ports_tristate", 1'b1, ports_tristate_o);
    chk_byte("g_pullup", 8'h03, {6'h00, g_pullup_o});
    rst_n_i = 1'b1;
    m_cfg = cfg;
    m_wr = (cfg != 8'h00);
    wait_rel(n);
    post_chk();
  endtask
  task automatic pin_reset();
    reset_pin_n_i = 1'b0;
    tick(1);
    chk_bit("reset_active", 1'b1, chip_reset_o);
    reset_pin_n_i = 1'b1;
    tick(1);
    chk_bit("reset_release", 1'b0, chip_reset_o);
  endtask
  // ---------------------------------------------
  // programmer request with model
  // ---------------------------------------------
  task automatic req(input flash_cmd_t c, input logic [15:0] a, input logic [7:0] d,
      input logic isp, input logic mode);
    logic ack, rf, rv, xr, sec, fv, xf;
    logic [7:0] rd, xd;
    flash_req_t fq, xq;
    ack = 1'b0;
    rf = 1'b0;
    rv = 1'b0;
    fv = 1'b0;
    rd = 8'h00;
    fq = '0;
    xq = '{cmd: c, addr: a, wdata: d};
    sec = m_cfg[5] && !isp;
    xr = ((c == CMD_WRITE || c == CMD_PAGE_ERASE) && (!mode || sec))
      || (c == CMD_WRITE && a == CFG_ADDR && m_wr);
    xd = (a == CFG_ADDR || a == CFG_ALIAS_ADDR) ? m_cfg : sec ? 8'hFF : a[7:0] ^ 8'h5A;
    xf = !xr && !(c == CMD_READ && (a == CFG_ADDR || a == CFG_ALIAS_ADDR));
    prog_valid_i = 1'b1;
    prog_req_i = xq;
    user_isp_i = isp;
    prog_mode_i = mode;
    tick(1);
    prog_valid_i = 1'b0;
    repeat (12) begin
      ack = ack | (prog_ack_o === 1'b1);
      rf = rf | (prog_refused_o === 1'b1);
      if (flash_valid_o === 1'b1) begin
        fv = 1'b1;
        fq = flash_req_o;
      end
      if (prog_rvalid_o === 1'b1) begin
        rv = 1'b1;
        rd = prog_rdata_o;
      end
      tick(1);
    end
    chk_bit("refused", xr, rf);
    chk_bit("accepted", !xr, ack);
    chk_bit("flash_fwd", xf, fv);
    if (xf) chk_bit("flash_req", 1'b1, fq === xq);
    if (c == CMD_READ) begin
      chk_bit("read_valid", 1'b1, rv);
      chk_byte("read_data", xd, rd);
    end
    if (!xr && c == CMD_WRITE && a == CFG_ADDR) begin
      m_cfg = d;
      m_wr = 1'b1;
    end
    if (!xr && (c == CMD_MASS_ERASE || (c == CMD_PAGE_ERASE && a[15:6] == CFG_ADDR[15:6])))
    begin
      m_cfg = 8'h00;
      m_wr = 1'b0;
    end
    chk_byte("cfg_byte", m_cfg, config_fuse_byte_o);
  endtask
  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    rst_n_i = 1'b0;
    reset_pin_n_i = 1'b1;
    brownout_i = 1'b0;
    clk_slow_i = 1'b0;
    halt_req_i = 1'b0;
    flash_cfg_i = 8'h00;
    prog_valid_i = 1'b0;
    prog_mode_i = 1'b0;
    user_isp_i = 1'b0;
    prog_req_i = '0;
    cpu_we_i = 1'b0;
    cpu_sel_i = SEL_PSW;
    cpu_wdata_i = 8'h00;
    void'($urandom(32'h1675));
    #1;
    por(8'h01);
    sio = 8'($urandom);
    cpu_we_i = 1'b1;
    for (i = 0; i < 16; i++) begin
      cpu_sel_i = cpu_sel_t'(i[3:0]);
      cpu_wdata_i = (i == 15) ? sio : (8'($urandom) | 8'h01);
      tick(1);
    end
    cpu_we_i = 1'b0;
    halt_req_i = 1'b1;
    tick(2);
    chk_bit("halt", 1'b1, halt_active_o);
    halt_req_i = 1'b0;
    pin_reset();
    chk_bit("halt", 1'b0, halt_active_o);
    post_chk();
    chk_byte("sio_kept", sio, kept_regs_o.serial_shift_reg);
    for (i = 0; i < 6; i++) req(CMD_READ, 16'($urandom) & 16'h1FFF, 8'h00, 1'b0, 1'b1);
    req(CMD_READ, CFG_ADDR, 8'h00, 1'b0, 1'b1);
    req(CMD_WRITE, CFG_ADDR, 8'h03, 1'b0, 1'b1);
    req(CMD_WRITE, 16'h0100, 8'($urandom), 1'b0, 1'b1);
    req(CMD_WRITE, 16'h0100, 8'($urandom), 1'b0, 1'b0);
    req(CMD_PAGE_ERASE, 16'h0040, 8'h00, 1'b0, 1'b1);
    clk_slow_i = 1'b1;
    tick(2);
    chk_bit("wd_pin", 1'b0, watchdog_out_pin_o);
    tick(3);
    clk_slow_i = 1'b0;
    tick(14 * T0);
    chk_bit("wd_pin", 1'b0, watchdog_out_pin_o);
    tick(20 * T0);
    chk_bit("wd_pin", 1'b1, watchdog_out_pin_o);
    brownout_i = 1'b1;
    tick(3);
    chk_bit("reset_active", 1'b1, chip_reset_o);
    brownout_i = 1'b0;
    wait_rel(n);
    chk_bit("bor_hold", 1'b1, n >= 240 * T0 && n <= 258 * T0);
    post_chk();
    por(8'h27);
    halt_req_i = 1'b1;
    tick(3);
    chk_bit("halt", 1'b0, halt_active_o);
    halt_req_i = 1'b0;
    for (i = 0; i < 3; i++) req(CMD_READ, 16'($urandom) & 16'h1FFF, 8'h00, 1'b0, 1'b1);
    req(CMD_READ, CFG_ADDR, 8'h00, 1'b0, 1'b1);
    req(CMD_READ, CFG_ALIAS_ADDR, 8'h00, 1'b0, 1'b1);
    req(CMD_WRITE, 16'h0200, 8'h3C, 1'b0, 1'b1);
    req(CMD_PAGE_ERASE, 16'h0200, 8'h00, 1'b0, 1'b1);
    req(CMD_WRITE, 16'h0200, 8'h3C, 1'b1, 1'b1);
    req(CMD_READ, 16'h0233, 8'h00, 1'b1, 1'b1);
    req(CMD_MASS_ERASE, 16'h0000, 8'h00, 1'b0, 1'b0);
    req(CMD_WRITE, CFG_ADDR, 8'h05, 1'b0, 1'b1);
    req(CMD_WRITE, CFG_ADDR, 8'h07, 1'b0, 1'b1);
    req(CMD_PAGE_ERASE, 16'h3FC0, 8'h00, 1'b0, 1'b1);
    req(CMD_WRITE, CFG_ADDR, 8'h01, 1'b0, 1'b1);
    results();
  end
endmodule

// *** verilog/option_security_reset_init.sv ***
/*
 * configuration byte decode, flash access gating and reset initialisation.
 * assumes the flash array sits outside and answers reads with a valid strobe,
 * and that all inputs are synchronous to ref_clk_i.
 */
// Overview of operation
// - config byte at 3FFF, written in programming modes
// - bit 5 secures flash except user ISP
// - bit 2 one disables watchdog, pin GPIO
// - bit 1 one forbids halt mode
// - bit 0 selects flash or boot ROM
// - secured external reads return FF, except config
// - secured: writes and page erases blocked
// - config readable always, also at alias FFFF
// - mass erase always accepted, clears security
// - reset pin or brownout initialises; pin ends halt
// - ports tri-state in reset; G pull-ups on
// - clear PC, PROCESSOR_STATUS_WORD, controls, segment; SP 6F
// - idle timer control cleared, fast-clock bit set
// - shift register and pointers survive warm reset
// - wake enable and edge cleared by reset
// - UART registers cleared, TX_BUFFER_EMPTY_FLAG set
// - ISP addresses cleared, timing preset 10 MHz
// - watchdog inhibited in reset, armed after, max window
// - clock error drives pin low, releases after 16-32
// - brownout released after idle timer underflow
`timescale 1ns/10ps
module option_security_reset_init #(
  parameter logic [7:0] PROG_TIMING_REG_RESET = option_security_reset_init_pkg::PROG_TIMING_REG_10MHZ,
  parameter int T0_DIVIDE = option_security_reset_init_pkg::T0_DIV
) (
  // clock and power-on reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // reset sources and power state
  input wire logic reset_pin_n_i,
  input wire logic brownout_i,
  input wire logic clk_slow_i,
  input wire logic halt_req_i,
  // nonvolatile configuration byte, loaded at power-on
  input wire logic [7:0] flash_cfg_i,
  // programmer request
  input wire logic prog_valid_i,
  input wire logic prog_mode_i,
  input wire logic user_isp_i,
  input wire option_security_reset_init_pkg::flash_req_t prog_req_i,
  // programmer answer
  output logic prog_ack_o,
  output logic prog_refused_o,
  output logic prog_rvalid_o,
  output logic [7:0] prog_rdata_o,
  // flash array side
  output logic flash_valid_o,
  output option_security_reset_init_pkg::flash_req_t flash_req_o,
  input wire logic flash_rvalid_i,
  input wire logic [7:0] flash_rdata_i,
  // cpu register writes
  input wire logic cpu_we_i,
  input wire option_security_reset_init_pkg::cpu_sel_t cpu_sel_i,
  input wire logic [7:0] cpu_wdata_i,
  // decoded options and register state
  output logic [7:0] config_fuse_byte_o,
  output logic boot_from_flash_o,
  output logic halt_active_o,
  output logic chip_reset_o,
  output option_security_reset_init_pkg::init_regs_t init_regs_o,
  output option_security_reset_init_pkg::kept_regs_t kept_regs_o,
  // pins
  output logic ports_tristate_o,
  output logic [1:0] g_pullup_o,
  output logic watchdog_out_pin_o,
  output logic watchdog_out_pin_oe_o,
  output logic [1:0] wd_window_o,
  output logic clk_mon_armed_o
);
  import option_security_reset_init_pkg::*;

  state_t st_reg;
  state_t st_next;
  logic t0_tick, chip_rst, secure, blocked, is_cfg, last_page, wd_on;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  assign t0_tick = (st_reg.div_cnt == 8'(T0_DIVIDE - 1));
  assign chip_rst = !reset_pin_n_i || brownout_i || st_reg.bor_hold;
  assign secure = st_reg.cfg[CFG_SECURE_BIT];
  assign blocked = secure && !user_isp_i;
  assign is_cfg = (prog_req_i.addr == CFG_ADDR);
  assign last_page = (prog_req_i.addr[15:PAGE_BITS] == CFG_ADDR[15:PAGE_BITS]);
  assign wd_on = !st_reg.cfg[CFG_WDOG_OFF_BIT];

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.ack = 1'b0;
    st_next.refused = 1'b0;
    st_next.rvalid = 1'b0;
    st_next.fl_valid = 1'b0;
    st_next.div_cnt = t0_tick ? 8'h00 : st_reg.div_cnt + 8'h01;
    // flash access gating
    if (prog_valid_i && !st_reg.in_reset) begin
      case (prog_req_i.cmd)
        CMD_READ: begin
          st_next.ack = 1'b1;
          if (is_cfg || prog_req_i.addr == CFG_ALIAS_ADDR) begin
            st_next.rvalid = 1'b1;
            st_next.rdata = st_reg.cfg;
          end else begin
            st_next.fl_valid = 1'b1;
            st_next.fl = prog_req_i;
            st_next.pend_mask = blocked;
          end
        end
        CMD_WRITE: begin
          if (!prog_mode_i || blocked) begin
            st_next.refused = 1'b1;
          end else if (is_cfg) begin
            if (st_reg.cfg_written) begin
              st_next.refused = 1'b1;
            end else begin
              st_next.ack = 1'b1;
              st_next.cfg = prog_req_i.wdata;
              st_next.cfg_written = 1'b1;
              st_next.fl_valid = 1'b1;
              st_next.fl = prog_req_i;
            end
          end else begin
            st_next.ack = 1'b1;
            st_next.fl_valid = 1'b1;
            st_next.fl = prog_req_i;
          end
        end
        CMD_PAGE_ERASE: begin
          if (!prog_mode_i || blocked) begin
            st_next.refused = 1'b1;
          end else begin
            st_next.ack = 1'b1;
            st_next.fl_valid = 1'b1;
            st_next.fl = prog_req_i;
            if (last_page) begin
              st_next.cfg = CFG_ERASED;
              st_next.cfg_written = 1'b0;
            end
          end
        end
        CMD_MASS_ERASE: begin
          st_next.ack = 1'b1;
          st_next.fl_valid = 1'b1;
          st_next.fl = prog_req_i;
          st_next.cfg = CFG_ERASED;
          st_next.cfg_written = 1'b0;
        end
        default: begin
          st_next.refused = 1'b1;
        end
      endcase
    end
    if (flash_rvalid_i) begin
      st_next.rvalid = 1'b1;
      st_next.rdata = st_reg.pend_mask ? SECURED_READ : flash_rdata_i;
    end
    // cpu register writes
    if (cpu_we_i && !st_reg.in_reset) begin
      case (cpu_sel_i)
        SEL_PSW: st_next.regs.processor_status_word = cpu_wdata_i;
        SEL_MAIN: st_next.regs.main_control_reg = cpu_wdata_i;
        SEL_IRQ: st_next.regs.irq_control_reg = cpu_wdata_i;
        SEL_T2: st_next.regs.second_timer_control = cpu_wdata_i;
        SEL_FT: st_next.regs.fast_timer_control = cpu_wdata_i;
        SEL_SEG: st_next.regs.segment = cpu_wdata_i;
        SEL_SP: st_next.regs.stack_ptr = cpu_wdata_i;
        SEL_IDLE_TIMER_CONTROL: st_next.regs.idle_timer_control = cpu_wdata_i;
        SEL_WAKE_ENABLE_REG: st_next.regs.wake_enable_reg = cpu_wdata_i;
        SEL_WAKE_EDGE_REG: st_next.regs.wake_edge_reg = cpu_wdata_i;
        SEL_PSR: st_next.regs.baud_prescaler_reg = cpu_wdata_i;
        SEL_UART: st_next.regs.uart_control_reg = cpu_wdata_i;
        SEL_PADLO: st_next.regs.prog_address_low = cpu_wdata_i;
        SEL_PADHI: st_next.regs.prog_address_high = cpu_wdata_i;
        SEL_PROG_TIMING_REG: st_next.regs.prog_timing_reg = cpu_wdata_i;
        SEL_SIO: st_next.kept.serial_shift_reg = cpu_wdata_i;
        default: st_next.regs.pc = st_reg.regs.pc;
      endcase
    end
    // halt entry
    if (halt_req_i && !st_reg.cfg[CFG_HALT_OFF_BIT] && !st_reg.in_reset) begin
      st_next.halt = 1'b1;
    end
    // brownout hold, released on idle timer underflow
    if (brownout_i) begin
      st_next.bor_hold = 1'b1;
      st_next.bor_cnt = BOR_PRESET;
    end else if (st_reg.bor_hold && t0_tick) begin
      if (st_reg.bor_cnt == 8'h00) begin
        st_next.bor_hold = 1'b0;
      end else begin
        st_next.bor_cnt = st_reg.bor_cnt - 8'h01;
      end
    end
    // clock monitor on the watchdog pin
    if (wd_on && !st_reg.in_reset && st_reg.cm_bit) begin
      if (clk_slow_i) begin
        st_next.wd_pin = 1'b0;
        st_next.cm_cnt = 5'h00;
      end else if (!st_reg.wd_pin && t0_tick) begin
        if (st_reg.cm_cnt == CM_RELEASE_TICKS - 5'h01) begin
          st_next.wd_pin = 1'b1;
        end else begin
          st_next.cm_cnt = st_reg.cm_cnt + 5'h01;
        end
      end
    end
    // synchronous initialisation
    st_next.in_reset = chip_rst;
    if (chip_rst) begin
      st_next.regs = '0;
      st_next.regs.stack_ptr = SP_RESET;
      st_next.regs.idle_timer_control = IDLE_TIMER_CONTROL_RESET;
      st_next.regs.uart_control_reg = UART_CTRL_RESET;
      st_next.regs.prog_timing_reg = PROG_TIMING_REG_RESET;
      st_next.halt = 1'b0;
      st_next.wd_win = WD_WIN_MAX;
      st_next.cm_bit = 1'b1;
      st_next.wd_pin = 1'b1;
      st_next.cm_cnt = 5'h00;
      st_next.ack = 1'b0;
      st_next.refused = 1'b0;
      st_next.fl_valid = 1'b0;
    end
    // power-on: load nonvolatile byte, clear kept registers
    if (!rst_n_i) begin
      st_next = '0;
      st_next.cfg = flash_cfg_i;
      st_next.cfg_written = (flash_cfg_i != CFG_ERASED);
      st_next.in_reset = 1'b1;
      st_next.bor_hold = 1'b1;
      st_next.bor_cnt = BOR_PRESET;
      st_next.wd_pin = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    st_reg <= st_next;
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign prog_ack_o = st_reg.ack;
  assign prog_refused_o = st_reg.refused;
  assign prog_rvalid_o = st_reg.rvalid;
  assign prog_rdata_o = st_reg.rdata;
  assign flash_valid_o = st_reg.fl_valid;
  assign flash_req_o = st_reg.fl;
  assign config_fuse_byte_o = st_reg.cfg;
  assign boot_from_flash_o = st_reg.cfg[CFG_FLASH_BOOT_BIT];
  assign halt_active_o = st_reg.halt;
  assign chip_reset_o = st_reg.in_reset;
  assign init_regs_o = st_reg.regs;
  assign kept_regs_o = st_reg.kept;
  assign ports_tristate_o = st_reg.in_reset;
  assign g_pullup_o = {2{st_reg.in_reset}};
  assign watchdog_out_pin_o = st_reg.wd_pin;
  assign watchdog_out_pin_oe_o = !st_reg.cfg[CFG_WDOG_OFF_BIT];
  assign wd_window_o = st_reg.wd_win;
  assign clk_mon_armed_o = st_reg.cm_bit;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_secure_read;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      (flash_rvalid_i && st_reg.pend_mask) |=> (prog_rvalid_o && prog_rdata_o == 8'hFF);
  endproperty
  a_secure_read: assert property (p_secure_read) else $error("secured read not FF");
  property p_cfg_read;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      (prog_valid_i && !st_reg.in_reset && !chip_rst && prog_req_i.cmd == CMD_READ
       && prog_req_i.addr == 16'hFFFF && !flash_rvalid_i)
      |=> (prog_rvalid_o && prog_rdata_o == $past(st_reg.cfg));
  endproperty
  a_cfg_read: assert property (p_cfg_read) else $error("alias read wrong");
  property p_secure_write;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      (prog_valid_i && !st_reg.in_reset && !chip_rst && secure && !user_isp_i
       && prog_req_i.cmd inside {CMD_WRITE, CMD_PAGE_ERASE})
      |=> (prog_refused_o && !flash_valid_o && $stable(st_reg.cfg));
  endproperty
  a_secure_write: assert property (p_secure_write) else $error("secured write passed");
  property p_mass_erase;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      (prog_valid_i && !st_reg.in_reset && !chip_rst && prog_req_i.cmd == CMD_MASS_ERASE)
      |=> (prog_ack_o && flash_valid_o && config_fuse_byte_o == 8'h00);
  endproperty
  a_mass_erase: assert property (p_mass_erase) else $error("mass erase refused");
  property p_reset_init;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      !reset_pin_n_i |=> (init_regs_o.stack_ptr == 8'h6F && init_regs_o.pc == 15'h0000
        && init_regs_o.idle_timer_control == 8'h40 && ports_tristate_o);
  endproperty
  a_reset_init: assert property (p_reset_init) else $error("reset values wrong");
  property p_tx_buffer_empty_flag;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      brownout_i |=> (init_regs_o.uart_control_reg[TX_BUFFER_EMPTY_FLAG_BIT] && init_regs_o.wake_enable_reg == 8'h00);
  endproperty
  a_tx_buffer_empty_flag: assert property (p_tx_buffer_empty_flag) else $error("uart reset wrong");
  property p_halt_off;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      (st_reg.cfg[CFG_HALT_OFF_BIT] && !halt_active_o) |=> !halt_active_o;
  endproperty
  a_halt_off: assert property (p_halt_off) else $error("halt entered while disabled");
  property p_pin_ends_halt;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      (halt_active_o && !reset_pin_n_i) |=> !halt_active_o;
  endproperty
  a_pin_ends_halt: assert property (p_pin_ends_halt) else $error("halt not ended");
  property p_cm_low;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      (wd_on && !st_reg.in_reset && !chip_rst && st_reg.cm_bit && clk_slow_i)
      |=> !watchdog_out_pin_o;
  endproperty
  a_cm_low: assert property (p_cm_low) else $error("clock error not on pin");
  property p_bor_release;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      $fell(st_reg.bor_hold) |-> ($past(st_reg.bor_cnt) == 8'h00 && $past(t0_tick));
  endproperty
  a_bor_release: assert property (p_bor_release) else $error("early brownout release");
endmodule

// *** verilog/option_security_reset_init_pkg.sv ***
/*
 * shared constants and carrier types for the configuration byte loader.
 * assumes one 100 MHz instruction clock and a synchronous active-low reset.
 */
package option_security_reset_init_pkg;
  // ---------------------------------------------------------------
  // flash addresses and configuration byte layout
  // ---------------------------------------------------------------
  localparam logic [15:0] CFG_ADDR = 16'h3FFF;
  localparam logic [15:0] CFG_ALIAS_ADDR = 16'hFFFF;
  localparam int PAGE_BITS = 6;
  localparam logic [7:0] CFG_ERASED = 8'h00;
  localparam logic [7:0] SECURED_READ = 8'hFF;
  localparam int CFG_SECURE_BIT = 5;
  localparam int CFG_WDOG_OFF_BIT = 2;
  localparam int CFG_HALT_OFF_BIT = 1;
  localparam int CFG_FLASH_BOOT_BIT = 0;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] SP_RESET = 8'h6F;
  localparam logic [7:0] IDLE_TIMER_CONTROL_RESET = 8'h40;
  localparam logic [7:0] UART_CTRL_RESET = 8'h02;
  localparam int TX_BUFFER_EMPTY_FLAG_BIT = 1;
  localparam logic [7:0] PROG_TIMING_REG_10MHZ = 8'h7F;
  localparam logic [1:0] WD_WIN_MAX = 2'h3;
  localparam logic [7:0] BOR_PRESET = 8'hF0;
  // ---------------------------------------------------------------
  // timing counts
  // ---------------------------------------------------------------
  localparam int T0_DIV = 10;
  localparam logic [4:0] CM_RELEASE_TICKS = 5'h10;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    CMD_READ = 2'b00,
    CMD_WRITE = 2'b01,
    CMD_PAGE_ERASE = 2'b10,
    CMD_MASS_ERASE = 2'b11
  } flash_cmd_t;
  typedef enum logic [3:0] {
    SEL_PSW = 4'b0000, SEL_MAIN = 4'b0001, SEL_IRQ = 4'b0010, SEL_T2 = 4'b0011,
    SEL_FT = 4'b0100, SEL_SEG = 4'b0101, SEL_SP = 4'b0110, SEL_IDLE_TIMER_CONTROL = 4'b0111,
    SEL_WAKE_ENABLE_REG = 4'b1000, SEL_WAKE_EDGE_REG = 4'b1001, SEL_PSR = 4'b1010, SEL_UART = 4'b1011,
    SEL_PADLO = 4'b1100, SEL_PADHI = 4'b1101, SEL_PROG_TIMING_REG = 4'b1110, SEL_SIO = 4'b1111
  } cpu_sel_t;
  typedef struct packed {
    flash_cmd_t cmd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } flash_req_t;
  typedef struct packed {
    logic [14:0] pc;
    logic [7:0] processor_status_word;
    logic [7:0] main_control_reg;
    logic [7:0] irq_control_reg;
    logic [7:0] second_timer_control;
    logic [7:0] fast_timer_control;
    logic [7:0] segment;
    logic [7:0] stack_ptr;
    logic [7:0] idle_timer_control;
    logic [7:0] wake_enable_reg;
    logic [7:0] wake_edge_reg;
    logic [7:0] baud_prescaler_reg;
    logic [7:0] uart_control_reg;
    logic [7:0] uart_rx_control_reg;
    logic [7:0] uart_irq_control_reg;
    logic [7:0] prog_address_low;
    logic [7:0] prog_address_high;
    logic [7:0] prog_timing_reg;
  } init_regs_t;
  typedef struct packed {
    logic [7:0] serial_shift_reg;
    logic [7:0] ram_ptr_b;
    logic [7:0] ram_ptr_x;
  } kept_regs_t;
  typedef struct packed {
    logic [7:0] cfg;
    logic cfg_written;
    logic pend_mask;
    logic ack;
    logic refused;
    logic rvalid;
    logic [7:0] rdata;
    logic fl_valid;
    flash_req_t fl;
    init_regs_t regs;
    kept_regs_t kept;
    logic in_reset;
    logic halt;
    logic [1:0] wd_win;
    logic cm_bit;
    logic wd_pin;
    logic [4:0] cm_cnt;
    logic bor_hold;
    logic [7:0] bor_cnt;
    logic [7:0] div_cnt;
  } state_t;
endpackage
